// [logic/aopr_pkg.sv]
package aopr_pkg;

   // Register slots, in the order of the register map.
   localparam int AOPR_NREG = 22;
   localparam int SLOT_PDC = 0;
   localparam int SLOT_INTH = 1;
   localparam int SLOT_INTL = 2;
   localparam int SLOT_INTF = 3;
   localparam int SLOT_MON = 4;
   localparam int SLOT_PS0 = 5;
   localparam int SLOT_PS1 = 6;
   localparam int SLOT_PS3 = 7;
   localparam int SLOT_PE0 = 8;
   localparam int SLOT_PE1 = 9;
   localparam int SLOT_PE3 = 10;
   localparam int SLOT_POL0 = 11;
   localparam int SLOT_POL1 = 12;
   localparam int SLOT_POL3 = 13;
   localparam int SLOT_MSK0 = 14;
   localparam int SLOT_MSK1 = 15;
   localparam int SLOT_MSK3 = 16;
   localparam int SLOT_KEEP0 = 17;
   localparam int SLOT_KEEP1 = 18;
   localparam int SLOT_SPU0 = 19;
   localparam int SLOT_SPU1 = 20;
   localparam int SLOT_SPU3 = 21;

   // Register indices; the bus byte address is four times the index.
   localparam logic [13:0] AOPR_INDEX [AOPR_NREG] = '{
      14'h22E0, 14'h22E3, 14'h22E4, 14'h22E5, 14'h22E6, 14'h22E7, 14'h22E8, 14'h22E9,
      14'h22EA, 14'h22EB, 14'h22EC, 14'h22ED, 14'h22EE, 14'h22EF, 14'h22F0, 14'h22F1,
      14'h22F2, 14'h22F7, 14'h22F8, 14'h22F9, 14'h22FA, 14'h22FB};

   localparam logic [7:0] AOPR_RESET [AOPR_NREG] = '{
      8'hD8, 8'h00, 8'h01, 8'h00, 8'h82, 8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h0C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   // Writable bits; the rest are reserved and read as zero, or status.
   localparam logic [7:0] AOPR_WMASK [AOPR_NREG] = '{
      8'hFB, 8'hFF, 8'hFF, 8'hFF, 8'h9B, 8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

   // Field positions in the power-down control register.
   localparam int PDC_BOD_BIT = 7;
   localparam int PDC_AREG_BIT = 6;
   localparam int PDC_SLEEP_TIMER_ENABLE_BIT = 5;
   localparam int PDC_FOSC_BIT = 4;
   localparam int PDC_SOSC_BIT = 3;
   localparam int PDC_MODE_LSB = 0;

   // Field positions in the power monitor register.
   localparam int MON_STEP_BIT = 7;
   localparam int MON_XTAL_BIT = 6;
   localparam int MON_EXT_LSB = 3;
   localparam int MON_RET_LSB = 0;

   localparam int AOPR_PINS = 24;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      AOPR_ACTIVE = 2'b00,
      AOPR_LIGHT_SLEEP = 2'b01,
      AOPR_DEEP_SLEEP = 2'b10,
      AOPR_OFF_SLEEP = 2'b11
   } aopr_mode_t;

endpackage : aopr_pkg

// [logic/aopr_wake_if.sv]
`timescale 1ns/1ns
interface aopr_wake_if;
   import aopr_pkg::*;
   logic [AOPR_PINS-1:0] levelHigh;
   logic [AOPR_PINS-1:0] pinEnable;
   aopr_mode_t powerDownSelect;
   logic timerEnable;
   logic timerExpired;
   logic wakeRequest;
   modport bank (output levelHigh, output pinEnable, output powerDownSelect, output timerEnable,
      output timerExpired, input wakeRequest);
   modport det (input levelHigh, input pinEnable, input powerDownSelect, input timerEnable,
      input timerExpired, output wakeRequest);
endinterface : aopr_wake_if

// [logic/aopr_wake.sv]
`timescale 1ns/1ns
module aopr_wake
   import aopr_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Settings from the bank.
   aopr_wake_if.det wk,
   // Port pins 0, 1 and 3, pin 0 of port 0 in bit 0.
   input wire logic [AOPR_PINS-1:0] pinLevel
);
   logic [AOPR_PINS-1:0] pinHit;
   logic sleeping;

   // A pin calls for wake-up when enabled and at its selected level.
   for (genvar p = 0; p < AOPR_PINS; p++) begin : g_pin
      assign pinHit[p] = wk.pinEnable[p] && (pinLevel[p] == wk.levelHigh[p]);
   end

   assign sleeping = (wk.powerDownSelect != AOPR_ACTIVE);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wk.wakeRequest <= 1'b0;
      end else begin
         wk.wakeRequest <= sleeping && ((|pinHit) || (wk.timerEnable && wk.timerExpired));
      end
   end

endmodule : aopr_wake

// [logic/aopr_bank.sv]
`timescale 1ns/1ns
// Operation
// - Every bank bit keeps its value through deep and off sleep modes.
// - Control bit 7 enables the brown-out detector; resets to one.
// - Control bit 5 enables the sleep timer on the slow oscillator; resets zero.
// - Control bit 4 enables the fast RC oscillator; resets to one.
// - Control bit 3 enables the slow RC oscillator; resets to one.
// - Control bit 2 is reserved, read-only, reads zero.
// - Control bits 1:0 select active, light, deep or off sleep; reset 00.
// - Interval is whole count, fraction count and two-bit extension.
// - Monitor bit 7 picks fine or coarse timer step; resets to one.
// - Coarse step interval: extension times 65536 plus whole plus fraction steps.
// - Fine step interval formula; software programs at least 71 us.
// - Monitor bit 6 reads crystal stable status; resets to zero.
// - Monitor bits 1:0 select data memory retention; reset 10.
// - Pull select per pin, zero down, one up; resets all ones.
// - Input mode per pin, zero tri-state, one pull on; resets all ones.
// - Wake polarity per pin, zero low level, one high level.
// - Wake mask per pin enables wake source; third port resets 0x0C.
// - Two general keep bytes, plain read-write, reset zero.
// - Strong pull-up per pin where bit is one; resets zero.
module aopr_bank
   import aopr_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // AXI4-Lite write address.
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [15:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // AXI4-Lite write data.
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response.
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read address.
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // AXI4-Lite read data.
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Status and events from the analog and timer blocks.
   input wire logic crystalOk,
   input wire logic sleepTimerExpired,
   input wire logic [AOPR_PINS-1:0] pinLevel,
   // Power and oscillator controls.
   output logic brownoutDetectEnable,
   output logic analogRegulatorEnable,
   output logic sleepTimerEnable,
   output logic fastRcOscEnable,
   output logic slowRcOscEnable,
   output logic [1:0] powerDownSelect,
   output logic [1:0] retentionSelect,
   // Sleep timer interval.
   output logic [15:0] intervalWholeCount,
   output logic [7:0] intervalFractionCount,
   output logic [1:0] intervalExtension,
   output logic intervalStepSelect,
   // Pin pad settings, port 0, 1 and 3.
   output logic [7:0] pullDirection0,
   output logic [7:0] pullDirection1,
   output logic [7:0] pullDirection3,
   output logic [7:0] inputPullEnable0,
   output logic [7:0] inputPullEnable1,
   output logic [7:0] inputPullEnable3,
   output logic [7:0] strongPullupEnable0,
   output logic [7:0] strongPullupEnable1,
   output logic [7:0] strongPullupEnable3,
   // General keep bytes.
   output logic [7:0] generalKeepByte0,
   output logic [7:0] generalKeepByte1,
   // Wake request to the power sequencer.
   output logic wakeRequest
);

   logic [7:0] regFile_r [AOPR_NREG];
   logic crystalStable_r;
   logic awHeld_r;
   logic wHeld_r;
   logic [13:0] wrIndex_r;
   logic [7:0] wrData_r;
   logic wrLane_r;
   logic commit;
   logic wrHit;
   logic [4:0] wrSlot;
   logic rdHit;
   logic [4:0] rdSlot;
   logic [7:0] rdByte;

   aopr_wake_if wk ();

   // Address decode: the index is the word address, bits 15:2.
   always_comb begin
      wrHit = 1'b0;
      wrSlot = 5'h00;
      rdHit = 1'b0;
      rdSlot = 5'h00;
      for (int s = 0; s < AOPR_NREG; s++) begin
         if (wrIndex_r == AOPR_INDEX[s]) begin
            wrHit = 1'b1;
            wrSlot = 5'(s);
         end
         if (s_axi_araddr[15:2] == AOPR_INDEX[s]) begin
            rdHit = 1'b1;
            rdSlot = 5'(s);
         end
      end
   end

   // A write commits once both address and data have been taken.
   assign commit = awHeld_r && wHeld_r && !s_axi_bvalid;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b1;
         awHeld_r <= 1'b0;
         wrIndex_r <= 14'h0000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         awHeld_r <= 1'b1;
         wrIndex_r <= s_axi_awaddr[15:2];
      end else if (commit) begin
         awHeld_r <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_wready <= 1'b1;
         wHeld_r <= 1'b0;
         wrData_r <= 8'h00;
         wrLane_r <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         wHeld_r <= 1'b1;
         wrData_r <= s_axi_wdata[7:0];
         wrLane_r <= s_axi_wstrb[0];
      end else if (commit) begin
         wHeld_r <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
      end else if (commit) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrHit ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Only the sys_rst power-on reset clears the bank; no power mode does.
   for (genvar s = 0; s < AOPR_NREG; s++) begin : g_reg
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            regFile_r[s] <= AOPR_RESET[s];
         end else if (commit && wrHit && wrLane_r && wrSlot == 5'(s)) begin
            regFile_r[s] <= (wrData_r & AOPR_WMASK[s]) | (regFile_r[s] & ~AOPR_WMASK[s]);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         crystalStable_r <= 1'b0;
      end else begin
         crystalStable_r <= crystalOk;
      end
   end

   // Status bits are merged on read; reserved bits stay zero.
   always_comb begin
      rdByte = regFile_r[rdSlot];
      if (rdSlot == 5'(SLOT_MON)) begin
         rdByte[MON_XTAL_BIT] = crystalStable_r;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdHit ? {24'h000000, rdByte} : 32'h00000000;
         s_axi_rresp <= rdHit ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Control outputs are the register bits themselves.
   assign brownoutDetectEnable = regFile_r[SLOT_PDC][PDC_BOD_BIT];
   assign analogRegulatorEnable = regFile_r[SLOT_PDC][PDC_AREG_BIT];
   assign sleepTimerEnable = regFile_r[SLOT_PDC][PDC_SLEEP_TIMER_ENABLE_BIT];
   assign fastRcOscEnable = regFile_r[SLOT_PDC][PDC_FOSC_BIT];
   assign slowRcOscEnable = regFile_r[SLOT_PDC][PDC_SOSC_BIT];
   assign powerDownSelect = regFile_r[SLOT_PDC][PDC_MODE_LSB +: 2];
   assign retentionSelect = regFile_r[SLOT_MON][MON_RET_LSB +: 2];
   assign intervalWholeCount = {regFile_r[SLOT_INTH], regFile_r[SLOT_INTL]};
   assign intervalFractionCount = regFile_r[SLOT_INTF];
   assign intervalExtension = regFile_r[SLOT_MON][MON_EXT_LSB +: 2];
   assign intervalStepSelect = regFile_r[SLOT_MON][MON_STEP_BIT];
   assign pullDirection0 = regFile_r[SLOT_PS0];
   assign pullDirection1 = regFile_r[SLOT_PS1];
   assign pullDirection3 = regFile_r[SLOT_PS3];
   assign inputPullEnable0 = regFile_r[SLOT_PE0];
   assign inputPullEnable1 = regFile_r[SLOT_PE1];
   assign inputPullEnable3 = regFile_r[SLOT_PE3];
   assign strongPullupEnable0 = regFile_r[SLOT_SPU0];
   assign strongPullupEnable1 = regFile_r[SLOT_SPU1];
   assign strongPullupEnable3 = regFile_r[SLOT_SPU3];
   assign generalKeepByte0 = regFile_r[SLOT_KEEP0];
   assign generalKeepByte1 = regFile_r[SLOT_KEEP1];

   // Wake detection settings.
   assign wk.levelHigh = {regFile_r[SLOT_POL3], regFile_r[SLOT_POL1], regFile_r[SLOT_POL0]};
   assign wk.pinEnable = {regFile_r[SLOT_MSK3], regFile_r[SLOT_MSK1], regFile_r[SLOT_MSK0]};
   assign wk.powerDownSelect = aopr_mode_t'(regFile_r[SLOT_PDC][PDC_MODE_LSB +: 2]);
   assign wk.timerEnable = regFile_r[SLOT_PDC][PDC_SLEEP_TIMER_ENABLE_BIT];
   assign wk.timerExpired = sleepTimerExpired;
   assign wakeRequest = wk.wakeRequest;

   aopr_wake u_wake (
      .clk(clk),
      .sys_rst(sys_rst),
      .wk(wk.det),
      .pinLevel(pinLevel)
   );

endmodule : aopr_bank

// [dv/aopr_bank_checker.sv]
`timescale 1ns/1ns
module aopr_bank_checker (
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Register bus.
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Controls and wake.
   input wire logic sleepTimerExpired,
   input wire logic brownoutDetectEnable,
   input wire logic analogRegulatorEnable,
   input wire logic sleepTimerEnable,
   input wire logic fastRcOscEnable,
   input wire logic slowRcOscEnable,
   input wire logic [1:0] powerDownSelect,
   input wire logic [1:0] retentionSelect,
   input wire logic intervalStepSelect,
   input wire logic wakeRequest
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channels open while a response is pending");
   write_reopen_a: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
      else $error("write channels not reopened after the response");
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped or changed before acceptance");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data not presented one cycle after the address");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped or changed before acceptance");
   rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   active_nowake_a: assert property (powerDownSelect == 2'b00 |=> !wakeRequest)
      else $error("wake request raised in active mode");
   timer_wake_a: assert property (powerDownSelect != 2'b00 && sleepTimerEnable && sleepTimerExpired
      |=> wakeRequest)
      else $error("timer expiry in sleep gave no wake request");
   reset_state_a: assert property (disable iff (1'b0) sys_rst |=> brownoutDetectEnable
      && analogRegulatorEnable && !sleepTimerEnable && fastRcOscEnable && slowRcOscEnable
      && powerDownSelect == 2'b00 && retentionSelect == 2'b10 && intervalStepSelect)
      else $error("controls wrong after reset");
endmodule : aopr_bank_checker
bind aopr_bank aopr_bank_checker aopr_bank_checker_inst (.*);

// [dv/testbench.sv]
`timescale 1ns/1ns
module testbench;
   import aopr_pkg::*;
   logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, crystalOk, sleepTimerExpired, wakeRequest;
   logic brownoutDetectEnable, analogRegulatorEnable, sleepTimerEnable, fastRcOscEnable, slowRcOscEnable;
   logic intervalStepSelect, st;
   logic [1:0] s_axi_bresp, s_axi_rresp, powerDownSelect, retentionSelect, intervalExtension, r;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [3:0] s_axi_wstrb;
   logic [7:0] v, intervalFractionCount, pullDirection0, pullDirection1, pullDirection3, inputPullEnable0;
   logic [7:0] inputPullEnable1, inputPullEnable3, strongPullupEnable0, strongPullupEnable1, strongPullupEnable3;
   logic [7:0] generalKeepByte0, generalKeepByte1;
   logic [15:0] s_axi_awaddr, s_axi_araddr, intervalWholeCount;
   logic [23:0] pinLevel;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [7:0] sh [AOPR_NREG];
   logic [7:0] rv [AOPR_NREG] = '{8'hD8, 8'h00, 8'h01, 8'h00, 8'h82, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   int fail_count = 0;
   int num_checks = 0;

   aopr_bank aopr_bank_inst (.*);

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic print_verdict;
      if (fail_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask : chk

   function automatic logic [15:0] adr(input int s);
      return {AOPR_INDEX[s], 2'b00};
   endfunction : adr

   // The crystal status bit tracks the input, which is held steady around reads.
   function automatic logic [7:0] expv(input int s);
      return sh[s] | ((s == SLOT_MON && crystalOk) ? 8'h40 : 8'h00);
   endfunction : expv

   task automatic wr(input logic [15:0] a, input logic [7:0] val, input logic en);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, val};
      s_axi_wstrb <= {3'b000, en};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic rst5;
      sys_rst <= 1'b1;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      sh = rv;
   endtask : rst5

   task automatic check_all;
      for (int s = 0; s < AOPR_NREG; s++) begin
         rd(adr(s));
         chk(d, {24'h0, expv(s)});
         chk(r, AXI_OKAY);
      end
   endtask : check_all

   task automatic outs;
      chk({brownoutDetectEnable, analogRegulatorEnable, sleepTimerEnable, fastRcOscEnable, slowRcOscEnable, 1'b0,
         powerDownSelect}, sh[SLOT_PDC]);
      chk({intervalStepSelect, 2'b00, intervalExtension, 1'b0, retentionSelect}, sh[SLOT_MON]);
      chk({intervalWholeCount, intervalFractionCount}, {sh[SLOT_INTH], sh[SLOT_INTL], sh[SLOT_INTF]});
      chk({pullDirection0, pullDirection1, pullDirection3}, {sh[SLOT_PS0], sh[SLOT_PS1], sh[SLOT_PS3]});
      chk({inputPullEnable0, inputPullEnable1, inputPullEnable3}, {sh[SLOT_PE0], sh[SLOT_PE1], sh[SLOT_PE3]});
      chk({strongPullupEnable0, strongPullupEnable1, strongPullupEnable3}, {sh[SLOT_SPU0], sh[SLOT_SPU1],
         sh[SLOT_SPU3]});
      chk({generalKeepByte0, generalKeepByte1}, {sh[SLOT_KEEP0], sh[SLOT_KEEP1]});
   endtask : outs

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      print_verdict();
   end

   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, crystalOk, sleepTimerExpired} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
      pinLevel = 24'hFFFFFF;
      sys_rst = 1'b1;
      void'($urandom(32'h44F1));
      rst5();
      check_all();
      outs();
      // Light sleep with the default port 3 mask: low pins 18 and 19 are wake sources.
      wr(adr(SLOT_PDC), 8'h99, 1'b1);
      sleepTimerExpired <= 1'b1;
      repeat (2) @(posedge clk);
      chk(wakeRequest, 1'b0);
      pinLevel[18] <= 1'b0;
      repeat (2) @(posedge clk);
      chk(wakeRequest, 1'b1);
      pinLevel <= 24'hFFFFFF;
      wr(adr(SLOT_PDC), 8'hBA, 1'b1);
      repeat (2) @(posedge clk);
      chk(wakeRequest, 1'b1);
      wr(adr(SLOT_PDC), 8'hF8, 1'b1);
      repeat (2) @(posedge clk);
      chk(wakeRequest, 1'b0);
      wr(16'h8B84, 8'h55, 1'b1);
      chk(r, AXI_SLVERR);
      rd(16'h8B84);
      chk(d, 32'h0);
      chk(r, AXI_SLVERR);
      sh[SLOT_PDC] = 8'hF8;
      repeat (3) begin
         crystalOk <= 1'($urandom);
         pinLevel <= 24'($urandom);
         sleepTimerExpired <= 1'($urandom);
         for (int s = 0; s < AOPR_NREG; s++) begin
            st = 1'($urandom);
            v = 8'($urandom);
            if (s == SLOT_PDC && v[1:0] != 2'b00) v[PDC_AREG_BIT] = 1'b0;
            wr(adr(s), v, st);
            if (st) sh[s] = v & AOPR_WMASK[s];
            chk(r, AXI_OKAY);
         end
         check_all();
         outs();
      end
      // The crystal bit must come back as status even right after a reset.
      crystalOk <= 1'b1;
      rst5();
      check_all();
      outs();
      print_verdict();
   end
endmodule : testbench
